/* File: verilog/flash_poll_pkg.sv */
// Constants, register map and pin carrier for the flash status poller
package flash_poll_pkg;
    localparam int ADDR_W = 20;
    localparam int DQ_W   = 16;
    localparam int REG_AW = 4;
    localparam int RD_W   = 32;

    // Status bit positions in the data word
    localparam int BIT_TOGGLE1 = 6;
    localparam int BIT_TIMEOUT = 5;
    localparam int BIT_WINDOW  = 3;

    // Flash reset command word
    localparam logic [DQ_W-1:0] CMD_RESET = 16'h00f0;

    // Timing
    localparam int CLK_NS    = 40;
    localparam int T_ACC_NS  = 120;
    localparam int T_WP_NS   = 40;
    localparam int SYNC_CYC  = 4;
    localparam int ACC_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC    = ((T_WP_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] READ_LAST = 4'(ACC_CYC + SYNC_CYC - 1);
    localparam logic [3:0] WP_LAST   = 4'(WP_CYC - 1);
    localparam logic [3:0] CNT_MAX   = 4'hf;
    localparam logic [3:0] PAIR_DONE = 4'h2;
    localparam logic [3:0] WIN_READS = 4'h3;

    // Register map
    localparam logic [REG_AW-1:0] REG_CTRL   = 4'h0;
    localparam logic [REG_AW-1:0] REG_ADDR   = 4'h4;
    localparam logic [REG_AW-1:0] REG_STATUS = 4'h8;
    localparam int CTRL_POLL  = 0;
    localparam int CTRL_WIN   = 1;
    localparam int CTRL_ABORT = 2;

    typedef enum logic [2:0] {S_IDLE, S_READ, S_EVAL, S_RST, S_RST_END} state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0]   dq_out;
        logic              dq_drive_n;
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
    } pins_t;

    localparam pins_t PINS_IDLE = '{addr: '0, dq_out: '0, dq_drive_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
endpackage

/* File: verilog/flash_status_poller.sv */
// Host-side status poller for a parallel NOR flash
`timescale 1ns/1ps
module flash_status_poller
    import flash_poll_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              reset,
    // Software register port
    input  wire logic [REG_AW-1:0] reg_addr,
    input  wire logic [RD_W-1:0]   reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [RD_W-1:0]   reg_rdata,
    // Flash pins
    output pins_t                  pins,
    input  wire logic [DQ_W-1:0]   dq_in,
    input  wire logic              ready_busy_in
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: change accepted once stages two and three agree
    logic [DQ_W-1:0] dq_s1_q, dq_s2_q, dq_s3_q, dq_q;
    logic            rb_s1_q, rb_s2_q, rb_s3_q, rb_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
            dq_s3_q <= '0;
            dq_q    <= '0;
            rb_s1_q <= 1'b1;
            rb_s2_q <= 1'b1;
            rb_s3_q <= 1'b1;
            rb_q    <= 1'b1;
        end else begin
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
            dq_s3_q <= dq_s2_q;
            if (dq_s2_q == dq_s3_q) dq_q <= dq_s3_q;
            rb_s1_q <= ready_busy_in;
            rb_s2_q <= rb_s1_q;
            rb_s3_q <= rb_s2_q;
            if (rb_s2_q == rb_s3_q) rb_q <= rb_s3_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and registers
    state_t            st_q, st_d;
    pins_t             pins_q, pins_d;
    logic [ADDR_W-1:0] addr_reg_q, addr_reg_d;
    logic [3:0]        cnt_q, cnt_d, reads_q, reads_d;
    logic              win_mode_q, win_mode_d, prev_tb_q, prev_tb_d;
    logic              recheck_q, recheck_d, done_q, done_d, fail_q, fail_d;
    logic              window_q, window_d, win_valid_q, win_valid_d;
    logic              accepted_q, accepted_d, aborted_q, aborted_d;
    logic [RD_W-1:0]   rdata_q, rdata_d;
    logic              busy, ctrl_wr, start;
    logic              tb;

    assign busy    = (st_q != S_IDLE);
    assign ctrl_wr = reg_wr && (reg_addr == REG_CTRL);
    // New starts are ignored while a sequence runs; abort first
    assign start   = ctrl_wr && !busy && (reg_wdata[CTRL_POLL] || reg_wdata[CTRL_WIN]);
    assign tb      = dq_q[BIT_TOGGLE1];

    always_comb begin
        st_d        = st_q;
        pins_d      = pins_q;
        addr_reg_d  = addr_reg_q;
        cnt_d       = cnt_q;
        reads_d     = reads_q;
        win_mode_d  = win_mode_q;
        prev_tb_d   = prev_tb_q;
        recheck_d   = recheck_q;
        done_d      = done_q;
        fail_d      = fail_q;
        window_d    = window_q;
        win_valid_d = win_valid_q;
        accepted_d  = accepted_q;
        aborted_d   = aborted_q;
        rdata_d     = '0;

        if (reg_wr && reg_addr == REG_ADDR && !busy) addr_reg_d = reg_wdata[ADDR_W-1:0];

        case (st_q)
            S_IDLE: begin
                pins_d = PINS_IDLE;
                if (start) begin
                    // Every start begins with a fresh pair of reads
                    reads_d     = '0;
                    recheck_d   = 1'b0;
                    win_mode_d  = reg_wdata[CTRL_WIN] && !reg_wdata[CTRL_POLL];
                    done_d      = 1'b0;
                    fail_d      = 1'b0;
                    win_valid_d = 1'b0;
                    accepted_d  = 1'b0;
                    aborted_d   = 1'b0;
                    cnt_d       = '0;
                    st_d        = S_READ;
                end
            end
            S_READ: begin
                pins_d.addr = addr_reg_q;
                pins_d.ce_n = 1'b0;
                pins_d.oe_n = 1'b0;
                cnt_d       = cnt_q + 4'h1;
                if (cnt_q == READ_LAST) begin
                    pins_d.oe_n = 1'b1;
                    pins_d.ce_n = 1'b1;
                    st_d        = S_EVAL;
                end
            end
            S_EVAL: begin
                reads_d   = (reads_q == CNT_MAX) ? reads_q : reads_q + 4'h1;
                prev_tb_d = tb;
                cnt_d     = '0;
                st_d      = S_READ;
                if (reads_q == '0) begin
                    st_d = S_READ;
                end else if (win_mode_q) begin
                    // Window bit is read on the read after the toggle pair, whether or not the pair showed acceptance
                    if (reads_q == PAIR_DONE - 4'h1) begin
                        accepted_d = (tb != prev_tb_q);
                    end else begin
                        window_d    = dq_q[BIT_WINDOW];
                        win_valid_d = 1'b1;
                        st_d        = S_IDLE;
                    end
                end else if (tb == prev_tb_q) begin
                    done_d = 1'b1;
                    st_d   = S_IDLE;
                end else if (recheck_q) begin
                    fail_d        = 1'b1;
                    pins_d.ce_n   = 1'b0;
                    pins_d.we_n   = 1'b0;
                    pins_d.dq_out = CMD_RESET;
                    pins_d.dq_drive_n = 1'b0;
                    st_d          = S_RST;
                end else if (dq_q[BIT_TIMEOUT]) begin
                    recheck_d = 1'b1;
                end
            end
            S_RST: begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == WP_LAST) begin
                    // Data held one cycle past the write strobe for hold time
                    pins_d.we_n = 1'b1;
                    st_d        = S_RST_END;
                end
            end
            S_RST_END: begin
                pins_d = PINS_IDLE;
                st_d   = S_IDLE;
            end
            default: begin
                pins_d = PINS_IDLE;
                st_d   = S_IDLE;
            end
        endcase

        // Abort lets software break off; a later start restarts from scratch
        // A failure decided in this cycle still gets its reset command written
        if (ctrl_wr && reg_wdata[CTRL_ABORT] && busy && st_q != S_RST && st_q != S_RST_END && st_d != S_RST) begin
            pins_d    = PINS_IDLE;
            aborted_d = 1'b1;
            st_d      = S_IDLE;
        end

        if (reg_rd) begin
            case (reg_addr)
                REG_ADDR:   rdata_d = RD_W'(addr_reg_q);
                REG_STATUS: rdata_d = {24'h000000, aborted_q, rb_q, accepted_q, win_valid_q,
                                       window_q, fail_q, done_q, busy};
                default:    rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_q        <= S_IDLE;
            pins_q      <= PINS_IDLE;
            addr_reg_q  <= '0;
            cnt_q       <= '0;
            reads_q     <= '0;
            win_mode_q  <= 1'b0;
            prev_tb_q   <= 1'b0;
            recheck_q   <= 1'b0;
            done_q      <= 1'b0;
            fail_q      <= 1'b0;
            window_q    <= 1'b0;
            win_valid_q <= 1'b0;
            accepted_q  <= 1'b0;
            aborted_q   <= 1'b0;
            rdata_q     <= '0;
        end else begin
            st_q        <= st_d;
            pins_q      <= pins_d;
            addr_reg_q  <= addr_reg_d;
            cnt_q       <= cnt_d;
            reads_q     <= reads_d;
            win_mode_q  <= win_mode_d;
            prev_tb_q   <= prev_tb_d;
            recheck_q   <= recheck_d;
            done_q      <= done_d;
            fail_q      <= fail_d;
            window_q    <= window_d;
            win_valid_q <= win_valid_d;
            accepted_q  <= accepted_d;
            aborted_q   <= aborted_d;
            rdata_q     <= rdata_d;
        end
    end

    assign pins      = pins_q;
    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_two_reads;
        @(posedge clock) disable iff (reset) $rose(done_q) |-> reads_q >= PAIR_DONE;
    endproperty
    a_two_reads: assert property (p_two_reads) else $error("done before two reads");

    property p_fail_after_recheck;
        @(posedge clock) disable iff (reset) $rose(fail_q) |-> $past(recheck_q) && reads_q >= WIN_READS;
    endproperty
    a_fail_after_recheck: assert property (p_fail_after_recheck) else $error("fail without recheck");

    property p_reset_cmd;
        @(posedge clock) disable iff (reset)
            $rose(fail_q) |-> ##[0:2] (!pins_q.we_n && !pins_q.ce_n && pins_q.dq_out == CMD_RESET);
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("no reset command after failure");

    property p_restart;
        @(posedge clock) disable iff (reset) start |=> reads_q == '0 && !recheck_q && st_q == S_READ;
    endproperty
    a_restart: assert property (p_restart) else $error("poll did not restart from first read");

    property p_read_addr;
        @(posedge clock) disable iff (reset) !pins_q.oe_n |-> pins_q.addr == addr_reg_q && pins_q.we_n;
    endproperty
    a_read_addr: assert property (p_read_addr) else $error("status read at wrong address");

    property p_window_after_pair;
        @(posedge clock) disable iff (reset) $rose(win_valid_q) |-> reads_q == WIN_READS && win_mode_q;
    endproperty
    a_window_after_pair: assert property (p_window_after_pair) else $error("window read too early");

    property p_window_done;
        @(posedge clock) disable iff (reset)
            (start && reg_wdata[CTRL_WIN] && !reg_wdata[CTRL_POLL]) |-> ##[1:40] (win_valid_q || aborted_q);
    endproperty
    a_window_done: assert property (p_window_done) else $error("window check not finished");

    property p_no_drive_on_read;
        @(posedge clock) disable iff (reset) !pins_q.dq_drive_n |-> pins_q.oe_n ##1 pins_q.oe_n;
    endproperty
    a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("bus driven during read");

endmodule

/* File: bench/flash_status_model.sv */
// Behavioural flash device answering status read cycles
`timescale 1ns/1ps
module flash_status_model
    import flash_poll_pkg::*;
(
    // Test set-up
    input  wire logic              load,
    input  wire logic [7:0]        cfg_toggles,
    input  wire logic [7:0]        cfg_timeout_at,
    input  wire logic              cfg_window,
    input  wire logic              cfg_suspend,
    // Flash pins
    input  wire pins_t             pins,
    output logic      [DQ_W-1:0]   dq,
    output logic                   ready_busy,
    // Observation
    output logic                   reset_seen,
    output logic      [ADDR_W-1:0] addr_seen
);
    // Plain array word seen outside the erasing sector while suspended; value is arbitrary
    localparam logic [DQ_W-1:0] ARRAY_WORD = 16'h5a81;
    localparam int              SECTOR_LSB = 15;

    logic [7:0]      left;
    logic            tog2;
    logic            running;
    logic            in_sector;
    logic [7:0]      reads;
    logic            tog;
    logic            cleared;
    logic            timeout;
    logic [DQ_W-1:0] word;
    logic [DQ_W-1:0] last;

    initial begin
        left = '0;
        reads = '0;
        tog = 1'b0;
        tog2 = 1'b0;
        cleared = 1'b0;
        reset_seen = 1'b0;
        addr_seen = '0;
        last = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Each load acts as a further erase command and restarts all timers
    always @(posedge load) begin
        left = cfg_toggles;
        reads = '0;
        cleared = 1'b0;
        reset_seen = 1'b0;
    end

    always @(negedge pins.oe_n) begin
        addr_seen = pins.addr;
    end

    // Toggle flips only after a read ends, so data holds while oe_n is low
    always @(posedge pins.oe_n) begin
        last = word;
        if (reads != 8'hff) begin
            reads = reads + 8'h01;
        end
        if (running && in_sector) begin
            tog2 = ~tog2;
        end
        // Suspended erase freezes both the toggle and the run count
        if (running && !cfg_suspend) begin
            tog = ~tog;
            left = left - 8'h01;
        end
    end

    // With cfg_window set, a started erase ignores commands unless it has already failed
    always @(posedge pins.we_n) begin
        if (pins.dq_drive_n == 1'b0 && pins.dq_out == CMD_RESET && !(cfg_window && running && !timeout)) begin
            left = '0;
            cleared = 1'b1;
            reset_seen = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign running    = (left != 8'h00);
    assign in_sector  = (pins.addr[ADDR_W-1:SECTOR_LSB] == '0);
    assign timeout    = !cleared && reads >= cfg_timeout_at;
    // Poll bit reads 0 while erasing and 1 once finished
    assign word       = (cfg_suspend && !in_sector) ? ARRAY_WORD
                      : {8'h00, !running, tog, timeout, 1'b0, cfg_window, tog2, 2'h0};
    // Released bus shows the inverse of the last word, never a stale match
    assign dq         = (!pins.ce_n && !pins.oe_n) ? word : ~last;
    assign ready_busy = !running || cfg_suspend;
endmodule

/* File: bench/tb_flash_status_poller.sv */
// Self-checking bench for the flash status poller
`timescale 1ns/1ps
module tb_flash_status_poller
    import flash_poll_pkg::*;
();
    typedef struct packed {
        logic       win;
        logic [7:0] tg;
        logic [7:0] to;
        logic       wv;
        logic [7:0] exp;
        logic [7:0] mask;
        logic       rst;
    } row_t;

    logic              clock, reset, reg_wr, reg_rd, load, cfg_window, cfg_suspend, ready_busy, reset_seen;
    logic [REG_AW-1:0] reg_addr;
    logic [RD_W-1:0]   reg_wdata, reg_rdata, d;
    logic [7:0]        cfg_toggles, cfg_timeout_at;
    pins_t             pins;
    logic [DQ_W-1:0]   flash_dq, dq_bus;
    logic [ADDR_W-1:0] addr_seen;
    int                failures, checked;

    row_t rows [6] = '{
        '{1'b0, 8'h00, 8'hff, 1'b0, 8'h42, 8'hf7, 1'b0},
        '{1'b0, 8'h03, 8'h03, 1'b0, 8'h42, 8'hf7, 1'b0},
        '{1'b0, 8'hff, 8'h02, 1'b0, 8'h44, 8'hf7, 1'b1},
        '{1'b1, 8'h03, 8'hff, 1'b0, 8'h70, 8'hf9, 1'b0},
        '{1'b1, 8'h03, 8'hff, 1'b1, 8'h78, 8'hf9, 1'b0},
        '{1'b1, 8'h00, 8'hff, 1'b0, 8'h50, 8'hf9, 1'b0}
    };

    assign dq_bus = pins.dq_drive_n ? flash_dq : pins.dq_out;

    flash_status_poller i_dut (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins), .dq_in(dq_bus),
        .ready_busy_in(ready_busy));

    flash_status_model i_flash (.load(load), .cfg_toggles(cfg_toggles), .cfg_timeout_at(cfg_timeout_at),
        .cfg_window(cfg_window), .cfg_suspend(cfg_suspend), .pins(pins), .dq(flash_dq),
        .ready_busy(ready_busy),
        .reset_seen(reset_seen), .addr_seen(addr_seen));

    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [REG_AW-1:0] a, input logic [RD_W-1:0] v);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [REG_AW-1:0] a, output logic [RD_W-1:0] v);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic wait_idle;
        logic [RD_W-1:0] s;
        for (int n = 0; n < 300; n++) begin
            rd(REG_STATUS, s);
            if (s[0] === 1'b0) begin
                repeat (8) @(posedge clock);
                return;
            end
        end
        failures++;
        close_out();
    endtask

    // Set-up lands one edge before load so the model never races it
    task automatic setup(input logic [7:0] tg, input logic [7:0] to, input logic wv);
        @(posedge clock);
        cfg_toggles <= tg;
        cfg_timeout_at <= to;
        cfg_window <= wv;
        @(posedge clock);
        load <= 1'b1;
        @(posedge clock);
        load <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        load = 1'b0;
        cfg_toggles = '0;
        cfg_timeout_at = 8'hff;
        cfg_window = 1'b0;
        cfg_suspend = 1'b0;
        repeat (5) @(posedge clock);
        chk("pins_in_reset", 64'(PINS_IDLE), 64'(pins));
        chk("rdata_in_reset", '0, 64'(reg_rdata));
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            setup(rows[i].tg, rows[i].to, rows[i].wv);
            wr(REG_CTRL, rows[i].win ? 32'h0000_0002 : 32'h0000_0001);
            wait_idle();
            rd(REG_STATUS, d);
            chk("status", 64'(rows[i].exp & rows[i].mask), 64'(d[7:0] & rows[i].mask));
            chk("reset_cmd", 64'(rows[i].rst), 64'(reset_seen));
        end
        // Abort mid-poll, refused address write, then a fresh poll
        setup(8'hff, 8'hff, 1'b0);
        wr(REG_ADDR, 32'h0002_a5c3);
        wr(REG_CTRL, 32'h0000_0001);
        repeat (20) @(posedge clock);
        wr(REG_ADDR, 32'h0000_0111);
        wr(REG_CTRL, 32'h0000_0004);
        wait_idle();
        rd(REG_STATUS, d);
        chk("aborted", 64'h80, 64'(d[7:0] & 8'h87));
        chk("read_addr", 64'h2a5c3, 64'(addr_seen));
        setup(8'h02, 8'hff, 1'b0);
        wr(REG_CTRL, 32'h0000_0001);
        wait_idle();
        rd(REG_STATUS, d);
        chk("restart", 64'h02, 64'(d[7:0] & 8'h87));
        // Suspended erase, read outside the erasing sector: plain data, ready high
        setup(8'hff, 8'hff, 1'b0);
        cfg_suspend <= 1'b1;
        wr(REG_CTRL, 32'h0000_0001);
        wait_idle();
        rd(REG_STATUS, d);
        chk("suspend_read", 64'h42, 64'(d[7:0] & 8'hc7));
        // Reset in mid-poll: pins fall idle at once and status clears
        setup(8'hff, 8'hff, 1'b0);
        cfg_suspend <= 1'b0;
        wr(REG_CTRL, 32'h0000_0001);
        repeat (10) @(posedge clock);
        reset <= 1'b1;
        @(posedge clock);
        chk("pins_mid_reset", 64'(PINS_IDLE), 64'(pins));
        reset <= 1'b0;
        rd(REG_STATUS, d);
        chk("status_after_reset", 64'h00, 64'(d[7:0] & 8'hbf));
        rd(4'hc, d);
        chk("unmapped", '0, 64'(d));
        close_out();
    end
endmodule
